// ### rsf_fill_core.sv
// file: repeat sector fill command handler with its register file
//
// Functional notes
// - action code 0002h selects the fill
// - function word picks pattern/sector, background/blocking
// - key words hold start, count, pattern
// - acceptance reports 00h, 50h, length 01h/00h
// - writes ascend from start until count done
// - zero count fills to last user block
// - never write hidden area when enabled
// - defective sectors may be reassigned meanwhile
// - out-of-range start or end gives error
// - zero start and count fills whole drive
// - complete error-free whole fill sets flag
// - other user writes clear the full flag
// - read reallocations leave the flag alone
// - background completes once data is received
// - non-status command ends a background fill
// - status FFFFh active, 0000h ok, else between
// - background: 0008h interrupted, 0009h media error
// - blocking completes after the whole fill
// - failure gives 51h, abort, code in count/number
// - blocking media error reports 0017h
// - extended status readable by status query
// - current block readable during background fill
//
// Added by the designer: the AXI4-Lite register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module rsf_fill_core import rsf_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// axi4-lite register bus
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [RSF_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [RSF_AW-1:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	// drive capacity and protected area setting
	input wire logic [RSF_LW-1:0] last_user_lba,
	input wire logic [RSF_LW-1:0] last_drive_lba,
	input wire logic hidden_en,
	// host events
	input wire logic sector_rcvd,
	input wire logic host_cmd_valid,
	input wire logic host_cmd_status,
	input wire logic user_write,
	// media write engine
	output logic wr_valid,
	input wire logic wr_ready,
	input wire logic wr_fail,
	output logic [RSF_LW-1:0] wr_lba,
	output logic [31:0] wr_pattern,
	output logic wr_use_sector,
	// task file result
	output logic tf_valid,
	output logic [7:0] tf_error,
	output logic [7:0] tf_status,
	output logic [7:0] tf_seccnt,
	output logic [7:0] tf_secnum,
	output logic [7:0] tf_cyl_lo,
	output logic [7:0] tf_cyl_hi,
	// status
	output logic fill_busy,
	output logic full_fill,
	output logic [15:0] ext_status
);

	typedef struct packed {
		rsf_state_type state;
		logic [15:0] action;
		logic [15:0] func;
		logic [RSF_LW-1:0] start;
		logic [RSF_LW-1:0] count;
		logic [RSF_LW-1:0] last;
		logic [RSF_LW-1:0] cur;
		logic [31:0] pattern;
		logic [15:0] ext;
		logic full;
		logic whole;
		logic blocking;
		logic sector;
		logic tf_valid;
		logic [7:0] tf_error;
		logic [7:0] tf_status;
		logic [7:0] tf_seccnt;
		logic [7:0] tf_secnum;
	} rsf_core_type;

	localparam rsf_core_type RSF_CORE_RST = '{state: RSF_ST_IDLE, default: '0};

	rsf_core_type s_r;
	rsf_core_type s_nxt;

	logic reg_wr_en;
	logic [RSF_AW-1:0] reg_wr_addr;
	logic [31:0] reg_wr_data;
	logic [3:0] reg_wr_strb;
	logic [RSF_AW-1:0] reg_rd_addr;
	logic [31:0] reg_rd_data;
	logic reg_rd_hit;
	logic go;
	logic [RSF_LW:0] end_sum;
	logic range_err;
	logic bg_intr;

	// bus front end
	rsf_axi_slave u_axi (
		.clk(clk),
		.rst_n(rst_n),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.reg_wr_en(reg_wr_en),
		.reg_wr_addr(reg_wr_addr),
		.reg_wr_data(reg_wr_data),
		.reg_wr_strb(reg_wr_strb),
		.reg_rd_addr(reg_rd_addr),
		.reg_rd_data(reg_rd_data),
		.reg_rd_hit(reg_rd_hit)
	);

	// outputs straight from state
	assign wr_valid = (s_r.state == RSF_ST_FILL);
	assign wr_lba = s_r.cur;
	assign wr_pattern = s_r.pattern;
	assign wr_use_sector = s_r.sector;
	assign tf_valid = s_r.tf_valid;
	assign tf_error = s_r.tf_error;
	assign tf_status = s_r.tf_status;
	assign tf_seccnt = s_r.tf_seccnt;
	assign tf_secnum = s_r.tf_secnum;
	assign tf_cyl_lo = RSF_TF_XFER_LO;
	assign tf_cyl_hi = RSF_TF_XFER_HI;
	assign fill_busy = (s_r.state == RSF_ST_DATA) || (s_r.state == RSF_ST_FILL);
	assign full_fill = s_r.full;
	assign ext_status = s_r.ext;
	assign go = reg_wr_en && (reg_wr_addr == RSF_A_CTRL) && reg_wr_strb[0] && reg_wr_data[RSF_GO_BIT];
	assign bg_intr = host_cmd_valid && !host_cmd_status && !s_r.blocking;

	// range check: last written block and overflow past last user block
	always_comb begin
		end_sum = {1'b0, s_r.start} + {1'b0, s_r.count} - {{RSF_LW{1'b0}}, 1'b1};
		// start or end beyond user area
		range_err = (s_r.start > last_user_lba) || ((s_r.count != '0) && (end_sum > {1'b0, last_user_lba}));
	end

	// register read mux
	always_comb begin
		reg_rd_hit = 1'b1;
		case (reg_rd_addr)
			RSF_A_CTRL: reg_rd_data = {31'h0000_0000, fill_busy};
			RSF_A_ACTION: reg_rd_data = {16'h0000, s_r.action};
			RSF_A_FUNC: reg_rd_data = {16'h0000, s_r.func};
			RSF_A_START_LO: reg_rd_data = s_r.start[31:0];
			RSF_A_START_HI: reg_rd_data = s_r.start[63:32];
			RSF_A_COUNT_LO: reg_rd_data = s_r.count[31:0];
			RSF_A_COUNT_HI: reg_rd_data = s_r.count[63:32];
			RSF_A_PATTERN: reg_rd_data = s_r.pattern;
			RSF_A_EXT: reg_rd_data = {16'h0000, s_r.ext};
			RSF_A_FLAGS: reg_rd_data = {31'h0000_0000, s_r.full};
			RSF_A_CUR_LO: reg_rd_data = s_r.cur[31:0];
			RSF_A_CUR_HI: reg_rd_data = s_r.cur[63:32];
			RSF_A_TF: reg_rd_data = {s_r.tf_status, s_r.tf_error, s_r.tf_secnum, s_r.tf_seccnt};
			default: begin
				reg_rd_data = 32'h0000_0000;
				reg_rd_hit = 1'b0;
			end
		endcase
	end

	// next state: key sector registers, command sequencing and full-fill flag
	always_comb begin
		logic [31:0] tmp;
		tmp = 32'h0000_0000;
		s_nxt = s_r;
		s_nxt.tf_valid = 1'b0;
		// key sector words land in registers
		if (reg_wr_en && (s_r.state == RSF_ST_IDLE)) begin
			case (reg_wr_addr)
				RSF_A_ACTION: begin
					tmp = rsf_merge({16'h0000, s_r.action}, reg_wr_data, reg_wr_strb);
					s_nxt.action = tmp[15:0];
				end
				RSF_A_FUNC: begin
					tmp = rsf_merge({16'h0000, s_r.func}, reg_wr_data, reg_wr_strb);
					s_nxt.func = tmp[15:0];
				end
				RSF_A_START_LO: s_nxt.start[31:0] = rsf_merge(s_r.start[31:0], reg_wr_data, reg_wr_strb);
				RSF_A_START_HI: s_nxt.start[63:32] = rsf_merge(s_r.start[63:32], reg_wr_data, reg_wr_strb);
				RSF_A_COUNT_LO: s_nxt.count[31:0] = rsf_merge(s_r.count[31:0], reg_wr_data, reg_wr_strb);
				RSF_A_COUNT_HI: s_nxt.count[63:32] = rsf_merge(s_r.count[63:32], reg_wr_data, reg_wr_strb);
				RSF_A_PATTERN: s_nxt.pattern = rsf_merge(s_r.pattern, reg_wr_data, reg_wr_strb);
				default: s_nxt.pattern = s_r.pattern;
			endcase
		end
		// read reallocations have no path here
		if (user_write) begin
			s_nxt.full = 1'b0;
		end
		case (s_r.state)
			RSF_ST_IDLE: begin
				if (go && (s_r.action == RSF_ACT_FILL)) begin
					s_nxt.state = RSF_ST_CHECK;
				end
			end
			RSF_ST_CHECK: begin
				s_nxt.blocking = rsf_fn_block(s_r.func);
				s_nxt.sector = rsf_fn_sector(s_r.func);
				s_nxt.cur = s_r.start;
				if (!rsf_fn_valid(s_r.func) || range_err) begin
					s_nxt.ext = rsf_fn_valid(s_r.func) ? RSF_ES_RANGE : RSF_ES_BAD_FN;
					s_nxt.tf_valid = 1'b1;
					s_nxt.tf_error = RSF_TF_ERR_ABRT;
					s_nxt.tf_status = RSF_TF_ST_ERR;
					s_nxt.tf_seccnt = s_nxt.ext[7:0];
					s_nxt.tf_secnum = s_nxt.ext[15:8];
					s_nxt.state = RSF_ST_IDLE;
				end else begin
					s_nxt.ext = RSF_ES_ACTIVE;
					if (s_r.count != '0) begin
						s_nxt.last = end_sum[RSF_LW-1:0];
					end else if ((s_r.start == '0) && !hidden_en) begin
						// whole drive when start and count zero and hidden area disabled
						s_nxt.last = last_drive_lba;
					end else begin
						// zero count runs to last user block
						s_nxt.last = last_user_lba;
					end
					s_nxt.whole = (s_r.start == '0) && (s_nxt.last >= last_user_lba);
					// acceptance result, one sector to move
					s_nxt.tf_error = RSF_TF_ERR_NONE;
					s_nxt.tf_status = RSF_TF_ST_OK;
					s_nxt.tf_valid = rsf_fn_sector(s_r.func) || !rsf_fn_block(s_r.func);
					s_nxt.state = rsf_fn_sector(s_r.func) ? RSF_ST_DATA : RSF_ST_FILL;
				end
			end
			RSF_ST_DATA: begin
				if (!s_r.blocking && host_cmd_valid && !host_cmd_status) begin
					s_nxt.ext = RSF_ES_INTR;
					s_nxt.state = RSF_ST_IDLE;
				// wait for the host's sector data
				end else if (sector_rcvd) begin
					s_nxt.tf_valid = !s_r.blocking;
					s_nxt.tf_error = RSF_TF_ERR_NONE;
					s_nxt.tf_status = RSF_TF_ST_OK;
					s_nxt.state = RSF_ST_FILL;
				end
			end
			RSF_ST_FILL: begin
				if (bg_intr) begin
					s_nxt.ext = RSF_ES_INTR;
					s_nxt.state = RSF_ST_IDLE;
				end else if (wr_ready) begin
					// engine may reassign, fill carries on
					if (wr_fail) begin
						s_nxt.ext = s_r.blocking ? RSF_ES_BLK_ERR : RSF_ES_BG_ERR;
						s_nxt.tf_valid = s_r.blocking;
						s_nxt.tf_error = RSF_TF_ERR_ABRT;
						s_nxt.tf_status = RSF_TF_ST_ERR;
						s_nxt.tf_seccnt = s_nxt.ext[7:0];
						s_nxt.tf_secnum = s_nxt.ext[15:8];
						s_nxt.state = RSF_ST_IDLE;
					end else begin
						// every error-free fill write clears the flag, so a whole fill cut after one such write leaves it clear
						s_nxt.full = 1'b0;
						if (s_r.cur == s_r.last) begin
							s_nxt.ext = RSF_ES_OK;
							// whole fill sets flag, set wins
							if (s_r.whole) begin
								s_nxt.full = 1'b1;
							end
							s_nxt.tf_valid = s_r.blocking;
							s_nxt.tf_error = RSF_TF_ERR_NONE;
							s_nxt.tf_status = RSF_TF_ST_OK;
							s_nxt.state = RSF_ST_IDLE;
						end else begin
							s_nxt.cur = s_r.cur + {{(RSF_LW-1){1'b0}}, 1'b1};
						end
					end
				end
			end
			default: s_nxt.state = RSF_ST_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= RSF_CORE_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// checks
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_ok_result;
		tf_valid && (tf_status == RSF_TF_ST_OK) |-> (tf_error == RSF_TF_ERR_NONE) && (tf_cyl_lo == 8'h01) && (tf_cyl_hi == 8'h00);
	endproperty
	a_ok_result: assert property (p_ok_result) else $error("success result fields wrong");

	property p_err_result;
		tf_valid && (tf_status == RSF_TF_ST_ERR) |-> (tf_error == RSF_TF_ERR_ABRT) && ({tf_secnum, tf_seccnt} == ext_status);
	endproperty
	a_err_result: assert property (p_err_result) else $error("error result fields wrong");

	property p_active_code;
		fill_busy |-> (ext_status == 16'hFFFF);
	endproperty
	a_active_code: assert property (p_active_code) else $error("busy without active code");

	property p_interrupt;
		wr_valid && bg_intr |=> !fill_busy && (ext_status == 16'h0008) ##1 !wr_valid;
	endproperty
	a_interrupt: assert property (p_interrupt) else $error("interrupt did not end fill");

	property p_bg_error;
		wr_valid && wr_ready && wr_fail && !s_r.blocking && !bg_intr |=> (ext_status == 16'h0009) && !tf_valid && !fill_busy;
	endproperty
	a_bg_error: assert property (p_bg_error) else $error("background error code wrong");

	property p_blk_error;
		wr_valid && wr_ready && wr_fail && s_r.blocking |=> tf_valid && (ext_status == 16'h0017) && (tf_status == 8'h51);
	endproperty
	a_blk_error: assert property (p_blk_error) else $error("blocking error completion wrong");

	property p_ascend;
		wr_valid && wr_ready && !wr_fail && !bg_intr |=> !wr_valid || (wr_lba == $past(wr_lba) + 64'h1);
	endproperty
	a_ascend: assert property (p_ascend) else $error("block address did not advance by one");

	property p_full_set;
		wr_valid && wr_ready && !wr_fail && !bg_intr && s_r.whole && (wr_lba == s_r.last) |=> full_fill && (ext_status == 16'h0000);
	endproperty
	a_full_set: assert property (p_full_set) else $error("full flag not set after whole fill");

	property p_user_clear;
		user_write && !wr_valid |=> !full_fill;
	endproperty
	a_user_clear: assert property (p_user_clear) else $error("user write left full flag set");

	property p_bg_done;
		(s_r.state == RSF_ST_DATA) && sector_rcvd && !s_r.blocking && !host_cmd_valid |=> tf_valid && (tf_status == 8'h50) ##1 !tf_valid;
	endproperty
	a_bg_done: assert property (p_bg_done) else $error("background completion missing");

	property p_reject;
		(s_r.state == RSF_ST_CHECK) && (!rsf_fn_valid(s_r.func) || range_err) |=> tf_valid && (tf_status == 8'h51) ##1 !wr_valid [*2];
	endproperty
	a_reject: assert property (p_reject) else $error("bad key sector not rejected");

	c_whole: cover property (wr_valid && wr_ready && !wr_fail && s_r.whole && (wr_lba == s_r.last));
	c_interrupt: cover property (wr_valid && bg_intr);
	c_blk_done: cover property (tf_valid && s_r.blocking && (tf_status == RSF_TF_ST_OK));
	c_reject: cover property (tf_valid && (ext_status == RSF_ES_RANGE));

endmodule // rsf_fill_core
`default_nettype wire

// ### rsf_pkg.sv
// package: constants, state type and helpers for the repeat sector fill block
package rsf_pkg;

	// bus and field widths
	localparam int RSF_AW = 8;
	localparam int RSF_LW = 64;

	// key sector action and function codes
	localparam logic [15:0] RSF_ACT_FILL = 16'h0002;
	localparam logic [15:0] RSF_FN_PAT_BG = 16'h0001;
	localparam logic [15:0] RSF_FN_SEC_BG = 16'h0002;
	localparam logic [15:0] RSF_FN_PAT_BLK = 16'h0101;
	localparam logic [15:0] RSF_FN_SEC_BLK = 16'h0102;

	// extended status codes
	localparam logic [15:0] RSF_ES_OK = 16'h0000;
	localparam logic [15:0] RSF_ES_ACTIVE = 16'hFFFF;
	localparam logic [15:0] RSF_ES_INTR = 16'h0008;
	localparam logic [15:0] RSF_ES_BG_ERR = 16'h0009;
	localparam logic [15:0] RSF_ES_BLK_ERR = 16'h0017;
	localparam logic [15:0] RSF_ES_BAD_FN = 16'h0004;
	localparam logic [15:0] RSF_ES_RANGE = 16'h0005;

	// task file result values
	localparam logic [7:0] RSF_TF_ERR_NONE = 8'h00;
	localparam logic [7:0] RSF_TF_ERR_ABRT = 8'h04;
	localparam logic [7:0] RSF_TF_ST_OK = 8'h50;
	localparam logic [7:0] RSF_TF_ST_ERR = 8'h51;
	localparam logic [7:0] RSF_TF_XFER_LO = 8'h01;
	localparam logic [7:0] RSF_TF_XFER_HI = 8'h00;

	// register byte addresses
	localparam logic [7:0] RSF_A_CTRL = 8'h00;
	localparam logic [7:0] RSF_A_ACTION = 8'h04;
	localparam logic [7:0] RSF_A_FUNC = 8'h08;
	localparam logic [7:0] RSF_A_START_LO = 8'h0C;
	localparam logic [7:0] RSF_A_START_HI = 8'h10;
	localparam logic [7:0] RSF_A_COUNT_LO = 8'h14;
	localparam logic [7:0] RSF_A_COUNT_HI = 8'h18;
	localparam logic [7:0] RSF_A_PATTERN = 8'h1C;
	localparam logic [7:0] RSF_A_EXT = 8'h20;
	localparam logic [7:0] RSF_A_FLAGS = 8'h24;
	localparam logic [7:0] RSF_A_CUR_LO = 8'h28;
	localparam logic [7:0] RSF_A_CUR_HI = 8'h2C;
	localparam logic [7:0] RSF_A_TF = 8'h30;

	// bit positions and responses
	localparam int RSF_GO_BIT = 0;
	localparam int RSF_FULL_BIT = 0;
	localparam logic [1:0] RSF_RESP_OKAY = 2'h0;
	localparam logic [1:0] RSF_RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {RSF_ST_IDLE, RSF_ST_CHECK, RSF_ST_DATA, RSF_ST_FILL} rsf_state_type;

	// one of the four defined function codes
	function automatic logic rsf_fn_valid(input logic [15:0] fn);
		return (fn == RSF_FN_PAT_BG) || (fn == RSF_FN_SEC_BG) || (fn == RSF_FN_PAT_BLK) || (fn == RSF_FN_SEC_BLK);
	endfunction

	// sector repeat variant
	function automatic logic rsf_fn_sector(input logic [15:0] fn);
		return (fn == RSF_FN_SEC_BG) || (fn == RSF_FN_SEC_BLK);
	endfunction

	// blocking variant
	function automatic logic rsf_fn_block(input logic [15:0] fn);
		return (fn == RSF_FN_PAT_BLK) || (fn == RSF_FN_SEC_BLK);
	endfunction

	// writable addresses
	function automatic logic rsf_wr_mapped(input logic [7:0] a);
		return (a == RSF_A_CTRL) || (a == RSF_A_ACTION) || (a == RSF_A_FUNC) || (a == RSF_A_START_LO) ||
			(a == RSF_A_START_HI) || (a == RSF_A_COUNT_LO) || (a == RSF_A_COUNT_HI) || (a == RSF_A_PATTERN);
	endfunction

	// byte-lane merge of a register write
	function automatic logic [31:0] rsf_merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] strb);
		logic [31:0] m;
		m = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				m[8*i +: 8] = new_v[8*i +: 8];
			end
		end
		return m;
	endfunction

endpackage

// ### rsf_axi_slave.sv
// file: axi4-lite slave front end for the repeat sector fill registers
`timescale 1ns/10ps
`default_nettype none
module rsf_axi_slave import rsf_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// write address channel
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [RSF_AW-1:0] s_axi_awaddr,
	// write data channel
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	// write response channel
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	// read address channel
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [RSF_AW-1:0] s_axi_araddr,
	// read data channel
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	// register side
	output logic reg_wr_en,
	output logic [RSF_AW-1:0] reg_wr_addr,
	output logic [31:0] reg_wr_data,
	output logic [3:0] reg_wr_strb,
	output logic [RSF_AW-1:0] reg_rd_addr,
	input wire logic [31:0] reg_rd_data,
	input wire logic reg_rd_hit
);

	typedef struct packed {
		logic aw_full;
		logic w_full;
		logic [RSF_AW-1:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} rsf_axi_type;

	rsf_axi_type s_r;
	rsf_axi_type s_nxt;

	// channel readies: one write and one read in flight
	assign s_axi_awready = !s_r.aw_full && !s_r.bvalid;
	assign s_axi_wready = !s_r.w_full && !s_r.bvalid;
	assign s_axi_arready = !s_r.rvalid;
	assign s_axi_bvalid = s_r.bvalid;
	assign s_axi_bresp = s_r.bresp;
	assign s_axi_rvalid = s_r.rvalid;
	assign s_axi_rdata = s_r.rdata;
	assign s_axi_rresp = s_r.rresp;
	assign reg_wr_en = s_r.aw_full && s_r.w_full && !s_r.bvalid;
	assign reg_wr_addr = s_r.awaddr;
	assign reg_wr_data = s_r.wdata;
	assign reg_wr_strb = s_r.wstrb;
	assign reg_rd_addr = s_axi_araddr;

	// next state: capture address and data in either order, answer after both
	always_comb begin
		s_nxt = s_r;
		if (s_axi_awvalid && s_axi_awready) begin
			s_nxt.aw_full = 1'b1;
			s_nxt.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			s_nxt.w_full = 1'b1;
			s_nxt.wdata = s_axi_wdata;
			s_nxt.wstrb = s_axi_wstrb;
		end
		if (reg_wr_en) begin
			s_nxt.aw_full = 1'b0;
			s_nxt.w_full = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = rsf_wr_mapped(s_r.awaddr) ? RSF_RESP_OKAY : RSF_RESP_SLVERR;
		end
		if (s_r.bvalid && s_axi_bready) begin
			s_nxt.bvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rdata = reg_rd_hit ? reg_rd_data : 32'h0000_0000;
			s_nxt.rresp = reg_rd_hit ? RSF_RESP_OKAY : RSF_RESP_SLVERR;
		end else if (s_r.rvalid && s_axi_rready) begin
			s_nxt.rvalid = 1'b0;
		end
	end

	// state register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

endmodule // rsf_axi_slave
`default_nettype wire

// ### rsf_media_model.sv
// media write engine model that answers fill requests
`timescale 1ns/10ps
`default_nettype none
module rsf_media_model import rsf_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// request from the fill block
	input wire logic wr_valid,
	input wire logic [RSF_LW-1:0] wr_lba,
	output logic wr_ready,
	output logic wr_fail,
	// bench control and record
	input wire logic [1:0] slow,
	input wire logic [RSF_LW-1:0] fail_lba,
	output int writes,
	output logic [RSF_LW-1:0] last
);
	logic [1:0] wait_c;
	// one write per request after slow extra cycles; a withdrawn request restarts the wait
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ready <= 1'b0;
			wr_fail <= 1'b0;
			wait_c <= 2'h0;
			writes <= 0;
			last <= '1;
		end else begin
			wr_ready <= 1'b0;
			wr_fail <= 1'b0;
			if (!wr_valid) begin
				wait_c <= 2'h0;
			end else if (!wr_ready && wait_c >= slow) begin
				wr_ready <= 1'b1;
				wr_fail <= (wr_lba == fail_lba);
				writes <= writes + 1;
				last <= wr_lba;
				wait_c <= 2'h0;
			end else if (!wr_ready) begin
				wait_c <= wait_c + 2'h1;
			end
		end
	end
endmodule // rsf_media_model
`default_nettype wire

// ### testbench.sv
// self-checking bench for the repeat sector fill block
`timescale 1ns/10ps
`default_nettype none
module testbench import rsf_pkg::*; ;
	logic clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, hidden_en, sector_rcvd, host_cmd_valid;
	logic host_cmd_status, user_write, wr_valid, wr_ready, wr_fail, wr_use_sector, tf_valid, fill_busy, full_fill;
	logic [7:0] s_axi_awaddr, s_axi_araddr, tf_error, tf_status, tf_seccnt, tf_secnum, tf_cyl_lo, tf_cyl_hi;
	logic [31:0] s_axi_wdata, s_axi_rdata, wr_pattern, rd;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, slow, resp;
	logic [63:0] last_user_lba, last_drive_lba, wr_lba, fail_lba, last;
	logic [15:0] ext_status;
	int writes, base, fail_count, checked;
	// design and engine model
	rsf_fill_core dut (.*);
	rsf_media_model media (.*);
	// 25 MHz clock
	always #20 clk = ~clk;
	// compare and count
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	// verdict and end of run
	task automatic results;
		$display("checked %0d failed %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// a wait that ran out of its bound
	task automatic tmo(input int n);
		if (n >= 300) begin
			fail_count++;
			results();
		end
	endtask
	// register write; handshakes sampled before the edge that completes them
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		logic ta, tw, tb;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		tb = 1'b0;
		for (n = 0; n < 300 && !tb; n++) begin
			@(negedge clk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			tb = s_axi_bvalid;
			resp = s_axi_bresp;
			@(posedge clk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
		end
		tmo(tb ? 0 : 300);
	endtask
	// register read
	task automatic rdr(input logic [7:0] a);
		int n;
		logic ta, tr;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		tr = 1'b0;
		for (n = 0; n < 300 && !tr; n++) begin
			@(negedge clk);
			ta = s_axi_arvalid && s_axi_arready;
			tr = s_axi_rvalid;
			rd = s_axi_rdata;
			resp = s_axi_rresp;
			@(posedge clk);
			if (ta) s_axi_arvalid <= 1'b0;
		end
		tmo(tr ? 0 : 300);
	endtask
	// key sector load and start
	task automatic cmd(input logic [15:0] fn, input logic [63:0] st, input logic [63:0] cn);
		base = writes;
		wr(RSF_A_ACTION, {16'h0000, RSF_ACT_FILL});
		wr(RSF_A_FUNC, {16'h0000, fn});
		wr(RSF_A_START_LO, st[31:0]);
		wr(RSF_A_START_HI, st[63:32]);
		wr(RSF_A_COUNT_LO, cn[31:0]);
		wr(RSF_A_COUNT_HI, cn[63:32]);
		wr(RSF_A_PATTERN, 32'hA5C30F1E);
		wr(RSF_A_CTRL, 32'h00000001);
	endtask
	// wait for the fill to go idle
	task automatic idle;
		int n;
		repeat (3) @(posedge clk);
		for (n = 0; n < 300 && fill_busy !== 1'b0; n++) @(posedge clk);
		@(posedge clk);
		tmo(n);
	endtask
	// main sequence
	initial begin
		{clk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, sector_rcvd} = '0;
		{host_cmd_valid, host_cmd_status, user_write, slow, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_bready, s_axi_rready, hidden_en, s_axi_wstrb} = 7'h7F;
		last_user_lba = 64'd20;
		last_drive_lba = 64'd30;
		fail_lba = '1;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		cmd(RSF_FN_PAT_BG, 64'd10, 64'd2);
		idle();
		chk({tf_cyl_hi, tf_cyl_lo, tf_error, tf_status}, 32'h00010050);
		chk(writes - base, 2);
		chk(last, 64'd11);
		chk(wr_pattern, 32'hA5C30F1E);
		rdr(RSF_A_EXT);
		chk(rd, 32'h0);
		$display("test 1 finished");
		slow <= 2'h3;
		cmd(RSF_FN_SEC_BLK, 64'd4, 64'd3);
		repeat (10) @(posedge clk);
		chk(fill_busy, 1);
		rdr(RSF_A_CUR_LO);
		chk(rd, 32'h00000004);
		sector_rcvd <= 1'b1;
		@(posedge clk);
		sector_rcvd <= 1'b0;
		idle();
		chk(last, 64'd6);
		chk(wr_use_sector, 1);
		cmd(RSF_FN_SEC_BG, 64'd7, 64'd1);
		sector_rcvd <= 1'b1;
		@(posedge clk);
		sector_rcvd <= 1'b0;
		@(negedge clk);
		chk({tf_valid, fill_busy, tf_status}, {2'b11, RSF_TF_ST_OK});
		idle();
		chk(last, 64'd7);
		$display("test 2 finished");
		slow <= 2'h0;
		cmd(RSF_FN_PAT_BG, 64'd0, 64'd0);
		idle();
		chk(last, 64'd20);
		chk(writes - base, 21);
		chk(full_fill, 1);
		user_write <= 1'b1;
		@(posedge clk);
		user_write <= 1'b0;
		repeat (2) @(posedge clk);
		chk(full_fill, 0);
		hidden_en <= 1'b0;
		cmd(RSF_FN_PAT_BG, 64'd0, 64'd0);
		idle();
		chk(last, 64'd30);
		chk(full_fill, 1);
		hidden_en <= 1'b1;
		$display("test 3 finished");
		cmd(16'h0003, 64'd1, 64'd1);
		idle();
		chk({tf_secnum, tf_seccnt, tf_error, tf_status}, 32'h00040451);
		cmd(RSF_FN_PAT_BLK, 64'd19, 64'd3);
		idle();
		chk({ext_status, tf_status}, 24'h000551);
		chk(writes - base, 0);
		$display("test 4 finished");
		slow <= 2'h3;
		cmd(RSF_FN_PAT_BG, 64'd0, 64'd0);
		repeat (12) @(posedge clk);
		chk(ext_status, 16'hFFFF);
		{host_cmd_valid, host_cmd_status} <= 2'h3;
		@(posedge clk);
		{host_cmd_valid, host_cmd_status} <= 2'h0;
		repeat (3) @(posedge clk);
		chk(fill_busy, 1);
		host_cmd_valid <= 1'b1;
		@(posedge clk);
		host_cmd_valid <= 1'b0;
		idle();
		chk(ext_status, 16'h0008);
		chk(full_fill, 0);
		$display("test 5 finished");
		slow <= 2'h0;
		fail_lba <= 64'd5;
		for (int i = 0; i < 2; i++) begin
			cmd(i ? RSF_FN_PAT_BLK : RSF_FN_PAT_BG, 64'd3, 64'd5);
			idle();
			chk(ext_status, i ? 16'h0017 : 16'h0009);
		end
		rdr(8'h40);
		chk(resp, RSF_RESP_SLVERR);
		$display("test 6 finished");
		results();
	end
endmodule // testbench
`default_nettype wire
